// file: dtc_chk_properties.sv
// port checker for the termination timing control
`timescale 1ns/1ps
`include "dtc_defs.vh"
module dtc_chk
#(
   parameter ADDR_W = 8
)
(
   // watched ports
   input wire              clk_in,
   input wire              rst_in,
   input wire [ADDR_W-1:0] addr_in,
   input wire [31:0]       wdata_in,
   input wire              wr_in,
   input wire              rd_in,
   input wire [31:0]       rdata_out,
   input wire              dll_locked_in,
   input wire [1:0]        term_sel_out,
   input wire [2:0]        term_value_out,
   input wire              term_on_out
);
   // shadow of the mode images, indexed by address bits 4:2
   reg  [4:2][17:0] mr_q;
   wire             mr_hit = (addr_in == `DTC_OFS_MR1) || (addr_in == `DTC_OFS_MR2) ||
                             (addr_in == `DTC_OFS_MR5);
   wire             sel_off = term_sel_out == `DTC_SEL_OFF;
   wire             sel_park = term_sel_out == `DTC_SEL_PARK;
   wire             sel_nom = term_sel_out == `DTC_SEL_NOM;
   wire             sel_wr = term_sel_out == `DTC_SEL_WR;
   always @(posedge clk_in or posedge rst_in)
      if (rst_in)
         mr_q <= {3{`DTC_MR_RST}};
      else if (wr_in && mr_hit)
         mr_q[addr_in[4:2]] <= wdata_in[17:0];

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   a_on_tracks_sel: assert property (term_on_out == !sel_off)
      else $error("term_on_out disagrees with term_sel_out");
   a_off_no_value: assert property (sel_off |-> term_value_out == 3'h0)
      else $error("value not zero while termination off");
   a_rdata_idle: assert property (!rd_in |=> rdata_out == 32'h00000000)
      else $error("read data outside its cycle");
   a_stat_echo: assert property (rd_in && addr_in == `DTC_OFS_STAT |=>
      rdata_out[5:0] == {$past(term_on_out), $past(term_value_out), $past(term_sel_out)})
      else $error("status read does not match outputs");
   a_nom_value: assert property (sel_nom && $stable(mr_q[2]) |->
      term_value_out == mr_q[2][`DTC_MR1_NOM] && mr_q[2][`DTC_MR1_NOM] != 3'h0)
      else $error("nominal value wrong");
   a_wr_value: assert property (sel_wr && $stable(mr_q[3]) |->
      term_value_out == mr_q[3][`DTC_MR2_WR] && mr_q[3][`DTC_MR2_DYN] != 2'h0)
      else $error("write termination value wrong");
   a_park_value: assert property (sel_park && $stable(mr_q[4]) |->
      term_value_out == mr_q[4][`DTC_MR5_PARK] && mr_q[4][`DTC_MR5_PARK] != 3'h0)
      else $error("parked value wrong");
   a_dll_off_no_wr: assert property (!dll_locked_in [*2] |-> !sel_wr)
      else $error("write termination with dll unlocked");

   c_write_term: cover property (sel_wr);
   c_nominal: cover property (sel_nom);
   c_read_off: cover property ($fell(term_on_out));
endmodule // dtc_chk

bind dtc_term_ctrl dtc_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_in(clk_in), .rst_in(rst_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .dll_locked_in(dll_locked_in), .term_sel_out(term_sel_out),
   .term_value_out(term_value_out), .term_on_out(term_on_out));

// file: dtc_ctl_model.sv
// memory controller model: command clock, termination pin and commands
`timescale 1ns/1ps
module dtc_ctl_model
(
   // link side
   output reg link_clk_out,
   output reg term_pin_out,
   output reg cmd_read_out,
   output reg cmd_write_out,
   output reg cmd_chop_out
);
   // free-running clock, odd offset so its edges never coincide with clk_in edges
   initial
   begin
      link_clk_out = 1'b0;
      term_pin_out = 1'b0;
      cmd_read_out = 1'b0;
      cmd_write_out = 1'b0;
      cmd_chop_out = 1'b0;
      #37;
      forever #200 link_clk_out = ~link_clk_out;
   end

   // pin kept until the next call, far past the hold time
   task issue(input logic rd, input logic wr, input logic chop, input logic pin);
   begin
      @(negedge link_clk_out);
      cmd_read_out <= rd;
      cmd_write_out <= wr;
      cmd_chop_out <= chop;
      term_pin_out <= pin;
      @(negedge link_clk_out);
      cmd_read_out <= 1'b0;
      cmd_write_out <= 1'b0;
      cmd_chop_out <= 1'b0;
   end
   endtask
endmodule // dtc_ctl_model

// file: dtc_defs.vh
// constants for the termination timing control block
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define DTC_OFS_LAT       8'h00
`define DTC_OFS_MODE      8'h04
`define DTC_OFS_MR1       8'h08
`define DTC_OFS_MR2       8'h0c
`define DTC_OFS_MR5       8'h10
`define DTC_OFS_STAT      8'h14

// ----------------------------------------------------------------------------
// latency register fields, six bits each
// ----------------------------------------------------------------------------
`define DTC_LAT_CL        5:0
`define DTC_LAT_CWL       13:8
`define DTC_LAT_AL        21:16
`define DTC_LAT_PL        29:24
`define DTC_LAT_RST       32'h0000090b

// ----------------------------------------------------------------------------
// mode register bits
// ----------------------------------------------------------------------------
`define DTC_MODE_PRE2     0
`define DTC_MODE_CRC      1
`define DTC_MODE_CHOP     2
`define DTC_MODE_OTF      3
`define DTC_MODE_RST      4'h0

// ----------------------------------------------------------------------------
// mode register images
// ----------------------------------------------------------------------------
`define DTC_MR1_NOM       10:8
`define DTC_MR2_WR        11:9
`define DTC_MR2_DYN       10:9
`define DTC_MR5_PARK      8:6
`define DTC_MR_RST        18'h00000

// ----------------------------------------------------------------------------
// termination select codes
// ----------------------------------------------------------------------------
`define DTC_SEL_OFF       2'h0
`define DTC_SEL_PARK      2'h1
`define DTC_SEL_NOM       2'h2
`define DTC_SEL_WR        2'h3

// ----------------------------------------------------------------------------
// latency offsets in command clock cycles
// ----------------------------------------------------------------------------
`define DTC_PRE1_SUB      8'h02
`define DTC_PRE2_SUB      8'h03
`define DTC_RET_CHOP      8'h04
`define DTC_RET_FULL      8'h06
`define DTC_CWN4_P1       8'h04
`define DTC_CWN4_P1C      8'h07
`define DTC_CWN4_P2       8'h05
`define DTC_CWN4_P2C      8'h08
`define DTC_CWN8_P1       8'h06
`define DTC_CWN8_P1C      8'h07
`define DTC_CWN8_P2       8'h07
`define DTC_CWN8_P2C      8'h08

`endif

// file: dtc_term_ctrl.v
// termination timing control: read disable, nominal, parked and write termination
// ----------------------------------------------------------------------------
// Summary of operation
// - read turns termination off at RL-2 or RL-3
// - off window lasts BL/2+2/3, plus CRC cycle
// - synchronous timing whenever DLL locked
// - nominal follows pin after direct latencies
// - direct latency is CAS_WRITE_LATENCY+AL+PL minus 2/3
// - read turn-off latency is CL+AL+PL minus 2/3
// - parked returns turn-off latency plus 4/6 (5/7)
// - never terminate while driving read data
// - dynamic mode when MR2 A9 or A10 set
// - values from MR1, MR2 and MR5 fields
// - idle: nominal by pin, parked when low
// - write selects write termination for window
// - change-to-write latency is WL-2 or WL-3
// - write-to-normal adds 4/7/5/8 or 6/7/7/8
// - no dynamic switching with DLL off
// - priority: disable, write, nominal, parked
// - read window is high impedance regardless
// ----------------------------------------------------------------------------
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "dtc_defs.vh"

module dtc_term_ctrl
#(
   parameter HIST_DEPTH = 64,
   parameter ADDR_W     = 8
)
(
   // clock and reset
   input  wire              clk_in,
   input  wire              rst_in,
   // register port
   input  wire [ADDR_W-1:0] addr_in,
   input  wire [31:0]       wdata_in,
   input  wire              wr_in,
   input  wire              rd_in,
   output reg  [31:0]       rdata_out,
   // memory link, sampled from the command clock domain
   input  wire              link_clk_in,
   input  wire              term_pin_in,
   input  wire              cmd_read_in,
   input  wire              cmd_write_in,
   input  wire              cmd_chop_in,
   // core status
   input  wire              dll_locked_in,
   // termination control
   output reg  [1:0]        term_sel_out,
   output reg  [2:0]        term_value_out,
   output reg               term_on_out
);

   // ----------------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------------
   function [7:0] sub_clamp;
      input [7:0] a;
      input [7:0] b;
      begin
         sub_clamp = (a > b) ? (a - b) : 8'h00;
      end
   endfunction

   // true if any command sits between lo (incl.) and hi (excl.) edges back
   function in_window;
      input [HIST_DEPTH-1:0] h;
      input [7:0]            lo;
      input [7:0]            hi;
      integer                i;
      begin
         in_window = 1'b0;
         for (i = 0; i < HIST_DEPTH; i = i + 1)
         begin
            if ((i >= lo) && (i < hi) && h[i])
            begin
               in_window = 1'b1;
            end
         end
      end
   endfunction

   function bit_at;
      input [HIST_DEPTH-1:0] h;
      input [7:0]            idx;
      integer                i;
      begin
         bit_at = 1'b0;
         for (i = 0; i < HIST_DEPTH; i = i + 1)
         begin
            if (i == idx)
            begin
               bit_at = h[i];
            end
         end
      end
   endfunction

   // ----------------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------------
   reg  [31:0]           lat_q;
   reg  [3:0]            mode_q;
   reg  [17:0]           mr1_q;
   reg  [17:0]           mr2_q;
   reg  [17:0]           mr5_q;
   wire [31:0]           stat_w;
   reg  [31:0]           rdata_d;

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         lat_q  <= `DTC_LAT_RST;
         mode_q <= `DTC_MODE_RST;
         mr1_q  <= `DTC_MR_RST;
         mr2_q  <= `DTC_MR_RST;
         mr5_q  <= `DTC_MR_RST;
      end
      else if (wr_in)
      begin
         case (addr_in)
            `DTC_OFS_LAT:  lat_q  <= wdata_in;
            `DTC_OFS_MODE: mode_q <= wdata_in[3:0];
            `DTC_OFS_MR1:  mr1_q  <= wdata_in[17:0];
            `DTC_OFS_MR2:  mr2_q  <= wdata_in[17:0];
            `DTC_OFS_MR5:  mr5_q  <= wdata_in[17:0];
            default:       lat_q  <= lat_q;
         endcase
      end
   end

   always @*
   begin
      case (addr_in)
         `DTC_OFS_LAT:  rdata_d = lat_q;
         `DTC_OFS_MODE: rdata_d = {28'h0000000, mode_q};
         `DTC_OFS_MR1:  rdata_d = {14'h0000, mr1_q};
         `DTC_OFS_MR2:  rdata_d = {14'h0000, mr2_q};
         `DTC_OFS_MR5:  rdata_d = {14'h0000, mr5_q};
         `DTC_OFS_STAT: rdata_d = stat_w;
         default:       rdata_d = 32'h00000000;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rdata_out <= 32'h00000000;
      end
      else if (rd_in)
      begin
         rdata_out <= rdata_d;
      end
      else
      begin
         rdata_out <= 32'h00000000;
      end
   end

   // ----------------------------------------------------------------------------
   // link sampling
   // ----------------------------------------------------------------------------
   // all five link lines share one synchroniser so their skew stays equal
   reg  [4:0]            sync1_q;
   reg  [4:0]            sync2_q;
   reg                   ck_prev_q;
   wire                  ck_rise;
   wire                  s_pin;
   wire                  s_read;
   wire                  s_write;
   wire                  s_chop;

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sync1_q   <= 5'h00;
         sync2_q   <= 5'h00;
         ck_prev_q <= 1'b0;
      end
      else
      begin
         sync1_q   <= {cmd_chop_in, cmd_write_in, cmd_read_in, term_pin_in, link_clk_in};
         sync2_q   <= sync1_q;
         ck_prev_q <= sync2_q[0];
      end
   end

   assign ck_rise = sync2_q[0] & ~ck_prev_q;
   assign s_pin   = sync2_q[1];
   assign s_read  = sync2_q[2];
   assign s_write = sync2_q[3];
   assign s_chop  = sync2_q[4];

   // ----------------------------------------------------------------------------
   // latency arithmetic
   // ----------------------------------------------------------------------------
   wire                  pre2     = mode_q[`DTC_MODE_PRE2];
   wire                  crc      = mode_q[`DTC_MODE_CRC];
   wire [7:0]            cl       = {2'h0, lat_q[`DTC_LAT_CL]};
   wire [7:0]            cas_write_latency      = {2'h0, lat_q[`DTC_LAT_CWL]};
   wire [7:0]            al       = {2'h0, lat_q[`DTC_LAT_AL]};
   wire [7:0]            pl       = {2'h0, lat_q[`DTC_LAT_PL]};
   wire [7:0]            pre_sub  = pre2 ? `DTC_PRE2_SUB : `DTC_PRE1_SUB;
   wire [7:0]            read_lat = cl + al + pl;
   wire [7:0]            write_latency = cas_write_latency + al + pl;
   wire [7:0]            crc_add  = {7'h00, crc};
   wire [7:0]            pre_add  = {7'h00, pre2};
   wire [7:0]            read_term_off_latency = sub_clamp(read_lat, pre_sub);
   wire [7:0]            direct_term_latency = sub_clamp(write_latency, pre_sub);
   wire [7:0]            change_to_write_term_latency = sub_clamp(write_latency, pre_sub);
   wire [7:0]            read_park_return_latency_chop =
                            read_term_off_latency + `DTC_RET_CHOP + pre_add + crc_add;
   wire [7:0]            read_park_return_latency_full =
                            read_term_off_latency + `DTC_RET_FULL + pre_add + crc_add;
   reg  [7:0]            cwn4_add;
   reg  [7:0]            cwn8_add;

   always @*
   begin
      case ({pre2, crc})
         2'h0:
         begin
            cwn4_add = `DTC_CWN4_P1;
            cwn8_add = `DTC_CWN8_P1;
         end
         2'h1:
         begin
            cwn4_add = `DTC_CWN4_P1C;
            cwn8_add = `DTC_CWN8_P1C;
         end
         2'h2:
         begin
            cwn4_add = `DTC_CWN4_P2;
            cwn8_add = `DTC_CWN8_P2;
         end
         default:
         begin
            cwn4_add = `DTC_CWN4_P2C;
            cwn8_add = `DTC_CWN8_P2C;
         end
      endcase
   end

   wire [7:0]            write_to_normal_latency_chop = change_to_write_term_latency + cwn4_add;
   wire [7:0]            write_to_normal_latency_full = change_to_write_term_latency + cwn8_add;

   // ----------------------------------------------------------------------------
   // command histories, one shift per rising command clock edge
   // ----------------------------------------------------------------------------
   reg  [HIST_DEPTH-1:0] pin_hist_q;
   reg  [HIST_DEPTH-1:0] rdf_hist_q;
   reg  [HIST_DEPTH-1:0] rdc_hist_q;
   reg  [HIST_DEPTH-1:0] wrf_hist_q;
   reg  [HIST_DEPTH-1:0] wrc_hist_q;
   // chop is fixed by mode, or taken per command when on-the-fly is set
   wire                  is_chop = mode_q[`DTC_MODE_CHOP] | (mode_q[`DTC_MODE_OTF] & s_chop);

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pin_hist_q <= {HIST_DEPTH{1'b0}};
         rdf_hist_q <= {HIST_DEPTH{1'b0}};
         rdc_hist_q <= {HIST_DEPTH{1'b0}};
         wrf_hist_q <= {HIST_DEPTH{1'b0}};
         wrc_hist_q <= {HIST_DEPTH{1'b0}};
      end
      else if (ck_rise)
      begin
         pin_hist_q <= {pin_hist_q[HIST_DEPTH-2:0], s_pin};
         rdf_hist_q <= {rdf_hist_q[HIST_DEPTH-2:0], s_read & ~is_chop};
         rdc_hist_q <= {rdc_hist_q[HIST_DEPTH-2:0], s_read & is_chop};
         wrf_hist_q <= {wrf_hist_q[HIST_DEPTH-2:0], s_write & ~is_chop};
         wrc_hist_q <= {wrc_hist_q[HIST_DEPTH-2:0], s_write & is_chop};
      end
   end

   // ----------------------------------------------------------------------------
   // termination decision
   // ----------------------------------------------------------------------------
   // value fields
   wire [2:0]            nominal_termination = mr1_q[`DTC_MR1_NOM];
   wire [2:0]            write_termination   = mr2_q[`DTC_MR2_WR];
   wire [2:0]            parked_termination  = mr5_q[`DTC_MR5_PARK];
   wire                  dyn_en = |mr2_q[`DTC_MR2_DYN];
   wire                  read_win =
      in_window(rdf_hist_q, read_term_off_latency, read_park_return_latency_full) |
      in_window(rdc_hist_q, read_term_off_latency, read_park_return_latency_chop);
   wire                  write_win = dyn_en & dll_locked_in & (
      in_window(wrf_hist_q, change_to_write_term_latency, write_to_normal_latency_full) |
      in_window(wrc_hist_q, change_to_write_term_latency, write_to_normal_latency_chop));
   // pin delayed by direct latency
   // without a locked dll the pin acts at once; analog timing lies elsewhere
   wire                  pin_del = dll_locked_in ? bit_at(pin_hist_q, direct_term_latency)
                                                 : pin_hist_q[0];
   reg  [1:0]            sel_d;
   reg  [2:0]            val_d;

   always @*
   begin
      if (read_win)
      begin
         sel_d = `DTC_SEL_OFF;
         val_d = 3'h0;
      end
      else if (write_win)
      begin
         sel_d = `DTC_SEL_WR;
         val_d = write_termination;
      end
      else if (pin_del && (nominal_termination != 3'h0))
      begin
         sel_d = `DTC_SEL_NOM;
         val_d = nominal_termination;
      end
      else if (parked_termination != 3'h0)
      begin
         sel_d = `DTC_SEL_PARK;
         val_d = parked_termination;
      end
      else
      begin
         sel_d = `DTC_SEL_OFF;
         val_d = 3'h0;
      end
   end

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         term_sel_out   <= `DTC_SEL_OFF;
         term_value_out <= 3'h0;
         term_on_out    <= 1'b0;
      end
      else
      begin
         term_sel_out   <= sel_d;
         term_value_out <= val_d;
         term_on_out    <= (sel_d != `DTC_SEL_OFF);
      end
   end

   assign stat_w = {22'h000000, dll_locked_in, dyn_en, write_win, read_win,
                    term_on_out, term_value_out, term_sel_out};

endmodule // dtc_term_ctrl

// file: dtc_term_ctrl_tb.sv
// self-checking bench for the termination timing control
`timescale 1ns/1ps
`include "dtc_defs.vh"
module dtc_term_ctrl_tb;
   typedef struct packed {
      logic [3:0]  cmd;
      logic [3:0]  mode;
      logic [31:0] lat;
      logic [17:0] mr2;
      logic [7:0]  lo;
      logic [7:0]  hi;
      logic [1:0]  sel;
   } dtc_row_t;
   reg         clk_in, rst_in, wr_in, rd_in, dll_locked_in;
   reg  [7:0]  addr_in;
   reg  [31:0] wdata_in;
   wire [31:0] rdata_out;
   wire [1:0]  term_sel_out;
   wire [2:0]  term_value_out;
   wire        term_on_out, link_clk, term_pin, cmd_read, cmd_write, cmd_chop;
   integer     n_errors, n_tests, i;
   dtc_row_t   rows [0:15];

   dtc_term_ctrl u_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .link_clk_in(link_clk),
      .term_pin_in(term_pin), .cmd_read_in(cmd_read), .cmd_write_in(cmd_write),
      .cmd_chop_in(cmd_chop), .dll_locked_in(dll_locked_in), .term_sel_out(term_sel_out),
      .term_value_out(term_value_out), .term_on_out(term_on_out));
   dtc_ctl_model u_ctl (.link_clk_out(link_clk), .term_pin_out(term_pin),
      .cmd_read_out(cmd_read), .cmd_write_out(cmd_write), .cmd_chop_out(cmd_chop));

   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
   begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   end
   endtask

   task end_of_test;
   begin
      $display("mismatches %0d, comparisons %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask

   task bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
   begin
      @(posedge clk_in);
      wr_in <= w;
      rd_in <= r;
      addr_in <= a;
      wdata_in <= d;
   end
   endtask

   task rchk(input logic [7:0] a, input logic [31:0] e);
   begin
      bus(1'b0, 1'b1, a, 32'h00000000);
      bus(1'b0, 1'b0, 8'h00, 32'h00000000);
      #1;
      check("rdata_out", e, rdata_out);
   end
   endtask

   // long flush so no window of the previous case reaches the next one
   task cfg(input logic [3:0] m, input logic [31:0] lat, input logic [17:0] mr2,
            input logic [17:0] mr1);
   begin
      bus(1'b1, 1'b0, `DTC_OFS_LAT, lat);
      bus(1'b1, 1'b0, `DTC_OFS_MODE, {28'h0000000, m});
      bus(1'b1, 1'b0, `DTC_OFS_MR1, {14'h0000, mr1});
      bus(1'b1, 1'b0, `DTC_OFS_MR2, {14'h0000, mr2});
      bus(1'b1, 1'b0, `DTC_OFS_MR5, 32'h000000c0);
      bus(1'b0, 1'b0, 8'h00, 32'h00000000);
      u_ctl.issue(1'b0, 1'b0, 1'b0, 1'b0);
      repeat (24) @(posedge link_clk);
   end
   endtask

   // cmd bits: chop, pin, write, read; edges counted from the command edge
   task scan(input logic [3:0] c, input logic [7:0] lo, input logic [7:0] hi,
             input logic [1:0] win, input logic [1:0] rest, input logic [2:0] wv);
      integer     k;
      logic [1:0] e;
      logic [2:0] v;
   begin
      u_ctl.issue(c[0], c[1], c[3], c[2]);
      for (k = 1; k < 24; k = k + 1)
      begin
         @(posedge link_clk);
         #300;
         e = (k >= lo && k < hi) ? win : rest;
         v = (e == `DTC_SEL_WR) ? wv : (e == `DTC_SEL_NOM) ? 3'h2 : {1'b0, e[0], e[0]};
         check("term_sel_out", 32'(e), 32'(term_sel_out));
         check("term_value_out", 32'(v), 32'(term_value_out));
         check("term_on_out", 32'(e != 2'h0), 32'(term_on_out));
      end
   end
   endtask

   initial
   begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   initial
   begin
      #2000000;
      n_errors = n_errors + 1;
      end_of_test;
   end

   initial
   begin
      n_errors = 0;
      n_tests = 0;
      rst_in = 1'b1;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 8'h00;
      wdata_in = 32'h00000000;
      dll_locked_in = 1'b1;
      rows[0] = {4'h1, 4'h0, 32'h0000090b, 18'h00a00, 8'h09, 8'h0f, 2'h0};
      rows[1] = {4'h1, 4'h1, 32'h0000090b, 18'h00a00, 8'h08, 8'h0f, 2'h0};
      rows[2] = {4'h1, 4'h6, 32'h01020908, 18'h00a00, 8'h09, 8'h0e, 2'h0};
      rows[3] = {4'h1, 4'h8, 32'h0000090a, 18'h00a00, 8'h08, 8'h0e, 2'h0};
      rows[4] = {4'h1, 4'h3, 32'h0000090b, 18'h00a00, 8'h08, 8'h10, 2'h0};
      rows[5] = {4'h2, 4'h0, 32'h0000090b, 18'h00a00, 8'h07, 8'h0d, 2'h3};
      rows[6] = {4'h2, 4'h2, 32'h0000090b, 18'h00a00, 8'h07, 8'h0e, 2'h3};
      rows[7] = {4'h2, 4'h1, 32'h0000090b, 18'h00a00, 8'h06, 8'h0d, 2'h3};
      rows[8] = {4'h2, 4'h3, 32'h0000090b, 18'h00a00, 8'h06, 8'h0e, 2'h3};
      rows[9] = {4'h2, 4'h4, 32'h0000090b, 18'h00a00, 8'h07, 8'h0b, 2'h3};
      rows[10] = {4'h2, 4'h6, 32'h0000090b, 18'h00a00, 8'h07, 8'h0e, 2'h3};
      rows[11] = {4'h2, 4'h5, 32'h0000090b, 18'h00a00, 8'h06, 8'h0b, 2'h3};
      rows[12] = {4'h2, 4'h7, 32'h0000090b, 18'h00a00, 8'h06, 8'h0e, 2'h3};
      rows[13] = {4'ha, 4'h8, 32'h01010909, 18'h00400, 8'h09, 8'h0d, 2'h3};
      rows[14] = {4'h4, 4'h0, 32'h0000090b, 18'h00a00, 8'h07, 8'hff, 2'h2};
      rows[15] = {4'h4, 4'h1, 32'h00020909, 18'h00a00, 8'h08, 8'hff, 2'h2};
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      rchk(`DTC_OFS_LAT, `DTC_LAT_RST);
      for (i = 1; i < 8; i = i + 1)
         if (i != 5)
            rchk(8'(4 * i), 32'h00000000);
      bus(1'b1, 1'b0, `DTC_OFS_MODE, 32'hffffffff);
      rchk(`DTC_OFS_MODE, 32'h0000000f);
      bus(1'b1, 1'b0, `DTC_OFS_MR1, 32'hffffffff);
      rchk(`DTC_OFS_MR1, 32'h0003ffff);
      bus(1'b1, 1'b0, 8'h1c, 32'hffffffff);
      rchk(8'h1c, 32'h00000000);
      for (i = 0; i < 16; i = i + 1)
      begin
         cfg(rows[i].mode, rows[i].lat, rows[i].mr2, 18'h00200);
         scan(rows[i].cmd, rows[i].lo, rows[i].hi, rows[i].sel, `DTC_SEL_PARK,
              rows[i].mr2[11:9]);
      end
      cfg(4'h0, 32'h0000090b, 18'h00a00, 18'h00200);
      u_ctl.issue(1'b0, 1'b0, 1'b0, 1'b1);
      repeat (12) @(posedge link_clk);
      // dll locked, dynamic on, no windows, nominal value 2 selected
      rchk(`DTC_OFS_STAT, 32'h0000032a);
      scan(4'h5, 8'h09, 8'h0f, `DTC_SEL_OFF, `DTC_SEL_NOM, 3'h5);
      scan(4'h6, 8'h07, 8'h0d, `DTC_SEL_WR, `DTC_SEL_NOM, 3'h5);
      cfg(4'h0, 32'h0000090b, 18'h00a00, 18'h00200);
      @(posedge clk_in);
      dll_locked_in <= 1'b0;
      scan(4'h2, 8'hff, 8'hff, `DTC_SEL_WR, `DTC_SEL_PARK, 3'h5);
      @(posedge clk_in);
      dll_locked_in <= 1'b1;
      cfg(4'h0, 32'h0000090b, 18'h00000, 18'h00200);
      scan(4'h2, 8'hff, 8'hff, `DTC_SEL_WR, `DTC_SEL_PARK, 3'h0);
      cfg(4'h0, 32'h0000090b, 18'h00a00, 18'h00000);
      scan(4'h4, 8'hff, 8'hff, `DTC_SEL_NOM, `DTC_SEL_PARK, 3'h5);
      // mid-run reset: outputs drop, registers and histories clear
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1;
      check("term_on_out", 32'h00000000, 32'(term_on_out));
      @(posedge clk_in);
      rst_in <= 1'b0;
      rchk(`DTC_OFS_MR5, 32'h00000000);
      repeat (12) @(posedge link_clk);
      #300;
      check("term_sel_out", 32'h00000000, 32'(term_sel_out));
      end_of_test;
   end
endmodule // dtc_term_ctrl_tb
